// ### rtl/core_memory_bus_cycle_control.sv
// Cycle control of a four-port core memory module, with its word store.
// How it works
// RULE_01: Read alone restores, write alone clears then writes, both read then write.
// RULE_02: Fourteen word-address bits reach 16K words; four bits select the module.
// RULE_03: A port requests only with module match or special mode, non-fast address, request.
// RULE_04: New requests are honoured only while no cycle runs.
// RULE_05: Highest pending port wins: A, then B, then C and D alternating.
// RULE_06: The winning port is found and latched before anything else.
// RULE_07: The winner's 18-bit address and both request lines are latched.
// RULE_08: One address acknowledge pulse follows the latch, then the core cycle starts.
// RULE_09: A read puts the sensed word on the bus at sense time, then restores.
// RULE_10: Read-write sends data and read restart, writes once write restart comes.
// RULE_11: In write-only cycles the processor may send data right after acknowledge.
// RULE_12: In write-only cycles the buffer is open from the acknowledge onward.
// RULE_13: A write restart during the clear phase is held for the write phase.
// RULE_14: The cycle waits for write restart, then writes before taking new requests.
`timescale 1ns/1ps
`default_nettype none
module core_memory_bus_cycle_control
    import core_cyc_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          ce,
    input  wire logic [SEL_W-1:0]              module_number,
    input  wire logic                          special_mode_flag,
    input  wire logic [NPORT-1:0]              read_request,
    input  wire logic [NPORT-1:0]              write_request,
    input  wire logic [NPORT-1:0]              write_restart,
    input  wire logic [NPORT-1:0][ADDR_W-1:0]  memory_address_lines,
    input  wire logic [NPORT-1:0][DATA_W-1:0]  write_data,
    output logic      [NPORT-1:0]              address_ack,
    output logic      [NPORT-1:0]              read_restart,
    output logic      [NPORT-1:0]              data_strobe,
    output logic      [DATA_W-1:0]             read_data,
    output logic                               buffer_open,
    output logic                               busy
);
    port_arb_if arb_bus ();

    logic [NPORT-1:0]   rq_rd_s1, rq_rd_s2, rq_wr_s1, rq_wr_s2;
    logic [NPORT-1:0]   wrs_s1, wrs_s2, wrs_s3;
    logic [NPORT-1:0][ADDR_W-1:0] adr_s1, adr_s2;
    logic [NPORT-1:0]   cycle_request, sel_match, fast_memory_select;
    cyc_state_t         state, next_state;
    logic [NPORT-1:0]   sel_port;
    logic [ADDR_W-1:0]  cur_addr;
    logic [1:0]         kind;
    logic [CNT_W-1:0]   cnt;
    logic [DATA_W-1:0]  wbuf;
    logic               wr_seen;
    logic [DATA_W-1:0]  mem [DEPTH];

    // Requests and write restart come from other cabinets: two flops each.
    // The third restart flop only serves the edge detector on clean data.
    // Addresses ride the same two stages, so a released address never meets a stale request.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {rq_rd_s1, rq_rd_s2, rq_wr_s1, rq_wr_s2} <= '0;
            {wrs_s1, wrs_s2, wrs_s3}                 <= '0;
            {adr_s1, adr_s2}                         <= '0;
        end else if (ce) begin
            {adr_s2, adr_s1} <= {adr_s1, memory_address_lines};
            {rq_rd_s2, rq_rd_s1} <= {rq_rd_s1, read_request};
            {rq_wr_s2, rq_wr_s1} <= {rq_wr_s1, write_request};
            {wrs_s3, wrs_s2, wrs_s1} <= {wrs_s2, wrs_s1, write_restart};
        end
    end

    // Per-port qualification: module select, outside fast memory, and a request.
    for (genvar i = 0; i < NPORT; i++) begin : g_qual
        assign sel_match[i] = (adr_s2[i][SEL_HI:SEL_LO] == module_number)
                              | special_mode_flag;                                // RULE_02
        assign fast_memory_select[i] = |adr_s2[i][FM_HI:FM_LO];                   // RULE_03
        assign cycle_request[i] = sel_match[i] & fast_memory_select[i]
                                  & (rq_rd_s2[i] | rq_wr_s2[i]);                  // RULE_03
    end

    // Requests only reach the arbiter while the memory is idle.
    assign arb_bus.req  = cycle_request & {NPORT{state == ST_IDLE}};              // RULE_04
    assign arb_bus.take = (state == ST_IDLE) & |arb_bus.grant;

    port_arbiter u_arb (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .bus    (arb_bus.arb)
    );

    // Decodes for the running cycle.
    wire [PIDX_W-1:0] sel_idx    = port_index(sel_port);
    wire [WORD_W-1:0] word_addr  = cur_addr[WORD_W-1:0];                          // RULE_02
    wire              phase_done = (cnt == CNT_ZERO);
    wire              wrs_rise   = wrs_s2[sel_idx] & ~wrs_s3[sel_idx];
    wire              sense_now  = (state == ST_READ) & phase_done;
    wire              wr_accept  = buffer_open & wrs_rise;

    // The buffer faces the bus from the acknowledge on for write-only cycles,
    // and after the sensed word is out for read-write cycles.
    assign buffer_open = ((kind == KIND_WRITE)
                          & (state inside {ST_ACK, ST_READ, ST_WAIT}))            // RULE_12
                       | ((kind == KIND_RMW) & (state == ST_WAIT));               // RULE_10
    assign busy        = (state != ST_IDLE);
    assign address_ack = sel_port & {NPORT{state == ST_ACK}};                     // RULE_08

    // Cycle sequencing.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:    if (arb_bus.take) next_state = ST_STROBE;                 // RULE_06
            ST_STROBE:  next_state = ST_ACK;                                      // RULE_07
            ST_ACK:     next_state = ST_READ;                                     // RULE_08
            ST_READ: begin
                if (phase_done) begin
                    next_state = (kind == KIND_READ) ? ST_RESTORE : ST_WAIT;      // RULE_01
                end
            end
            ST_RESTORE: if (phase_done) next_state = ST_IDLE;                     // RULE_09
            ST_WAIT:    if (wr_seen) next_state = ST_WRITE;                       // RULE_14
            ST_WRITE:   if (phase_done) next_state = ST_IDLE;                     // RULE_14
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Phase timer, loaded on entry to each timed phase.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= CNT_ZERO;
        end else if (ce) begin
            if (next_state != state) begin
                unique case (next_state)
                    ST_READ:    cnt <= READ_CYC - CNT_ONE;
                    ST_RESTORE: cnt <= RESTORE_CYC - CNT_ONE;
                    ST_WRITE:   cnt <= WRITE_CYC - CNT_ONE;
                    default:    cnt <= CNT_ZERO;
                endcase
            end else if (!phase_done) begin
                cnt <= cnt - CNT_ONE;
            end
        end
    end

    // Winner first, then its address and cycle kind one edge later.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_port <= '0;
            cur_addr <= '0;
            kind     <= KIND_NONE;
        end else if (ce) begin
            if (arb_bus.take) begin
                sel_port <= arb_bus.grant;                                        // RULE_06
            end
            if (state == ST_STROBE) begin
                cur_addr <= adr_s2[sel_idx];                                      // RULE_07
                kind     <= {rq_rd_s2[sel_idx], rq_wr_s2[sel_idx]};               // RULE_07
            end
        end
    end

    // Write restart is remembered whenever it lands while the buffer is open,
    // so early data in a write-only cycle is not lost during the clear phase.
    // The clear happens only when the cycle ends, where no new set can arrive.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_seen <= 1'b0;
            wbuf    <= '0;
        end else if (ce) begin
            if (wr_accept) begin
                wr_seen <= 1'b1;                                                  // RULE_13
                wbuf    <= write_data[sel_idx];                                   // RULE_11
            end else if (state == ST_IDLE) begin
                wr_seen <= 1'b0;
            end
        end
    end

    // Sense strobe: the word goes out for reads and read-writes; read-writes
    // also tell the processor to continue. Write-only cycles put nothing out.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            read_data    <= '0;
            data_strobe  <= '0;
            read_restart <= '0;
        end else if (ce) begin
            data_strobe  <= sel_port & {NPORT{sense_now & kind[1]}};              // RULE_09
            read_restart <= sel_port & {NPORT{sense_now & (kind == KIND_RMW)}};   // RULE_10
            if (sense_now & kind[1]) begin
                read_data <= mem[word_addr];                                      // RULE_09
            end
        end
    end

    // The store itself has no reset; core contents survive a reset anyway.
    always_ff @(posedge clk) begin
        if (ce && state == ST_WRITE && phase_done) begin
            mem[word_addr] <= wbuf;                                               // RULE_14
        end
    end

    // Checks, sampled only on enabled edges.
    localparam int A_MAX = 40;
    default clocking cb @(posedge clk iff ce); endclocking
    default disable iff (!arst_n);

    property p_idle_start;
        state == ST_IDLE && |cycle_request |=> state == ST_STROBE;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("request not taken"); // RULE_03
    property p_busy_block;
        state != ST_IDLE |-> arb_bus.req == 4'h0;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("request during cycle"); // RULE_04
    property p_port_latch;
        arb_bus.take |=> sel_port == $past(arb_bus.grant) && state == ST_STROBE;
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("winner not latched"); // RULE_06
    property p_addr_latch;
        state == ST_STROBE |=> cur_addr == $past(adr_s2[sel_idx]);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // RULE_07
    property p_one_ack;
        state == ST_STROBE |=> address_ack == sel_port ##1 address_ack == 4'h0;
    endproperty
    a_one_ack: assert property (p_one_ack) else $error("acknowledge not single"); // RULE_08
    property p_read_out;
        state == ST_ACK && kind == KIND_READ |-> ##[1:A_MAX] data_strobe == sel_port;
    endproperty
    a_read_out: assert property (p_read_out) else $error("read word not sent"); // RULE_09
    property p_rmw_restart;
        |data_strobe && kind == KIND_RMW |-> read_restart == data_strobe;
    endproperty
    a_rmw_restart: assert property (p_rmw_restart) else $error("no read restart"); // RULE_10
    property p_wr_open;
        state == ST_ACK && kind == KIND_WRITE |-> buffer_open;
    endproperty
    a_wr_open: assert property (p_wr_open) else $error("buffer closed at ack"); // RULE_12
    property p_early_keep;
        state == ST_READ && wr_accept |=> wr_seen throughout (state != ST_IDLE)[*2];
    endproperty
    a_early_keep: assert property (p_early_keep) else $error("restart lost"); // RULE_13
    property p_wait_hold;
        state == ST_WAIT && !wr_seen |=> state == ST_WAIT || $past(wr_accept);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait left early"); // RULE_14
    property p_write_end;
        state == ST_WAIT && wr_seen |=> state == ST_WRITE ##[1:A_MAX] state == ST_IDLE;
    endproperty
    a_write_end: assert property (p_write_end) else $error("write not finished"); // RULE_14

    c_read:  cover property (state == ST_RESTORE ##1 state == ST_IDLE);
    c_rmw:   cover property (|read_restart ##[1:A_MAX] state == ST_WRITE);
    c_early: cover property (state == ST_READ && wr_accept && kind == KIND_WRITE);
    c_port_d: cover property (arb_bus.take && arb_bus.grant[PORT_D]);
endmodule // core_memory_bus_cycle_control
`default_nettype wire

// ### rtl/core_cyc_pkg.sv
// Shared constants, state codes and helpers for the core memory cycle control.
package core_cyc_pkg;
    // Bus geometry: four processor ports, 18-bit bus address, 36-bit words.
    localparam int NPORT   = 4;
    localparam int ADDR_W  = 18;
    localparam int WORD_W  = 14;
    localparam int DATA_W  = 36;
    localparam int SEL_W   = 4;
    localparam int PIDX_W  = 2;
    localparam int DEPTH   = 16384;
    // Address field positions; bus bit n sits at index 35-n.
    localparam int SEL_HI  = 17;
    localparam int SEL_LO  = 14;
    localparam int FM_HI   = 13;
    localparam int FM_LO   = 4;
    // Port indices.
    localparam int PORT_A  = 0;
    localparam int PORT_B  = 1;
    localparam int PORT_C  = 2;
    localparam int PORT_D  = 3;
    // Core phase timing in nanoseconds and the derived cycle counts.
    localparam int CLK_NS    = 50;
    localparam int READ_NS   = 500;
    localparam int RESTORE_NS = 500;
    localparam int WRITE_NS  = 500;
    localparam int CNT_W     = 5;
    localparam logic [CNT_W-1:0] READ_CYC    = CNT_W'((READ_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] RESTORE_CYC = CNT_W'((RESTORE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] WRITE_CYC   = CNT_W'((WRITE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CNT_ONE     = 5'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
    // Cycle kinds, coded as {read_request, write_request}.
    localparam logic [1:0] KIND_READ  = 2'h2;
    localparam logic [1:0] KIND_WRITE = 2'h1;
    localparam logic [1:0] KIND_RMW   = 2'h3;
    localparam logic [1:0] KIND_NONE  = 2'h0;
    typedef enum logic [6:0] {
        ST_IDLE    = 7'h01,
        ST_STROBE  = 7'h02,
        ST_ACK     = 7'h04,
        ST_READ    = 7'h08,
        ST_RESTORE = 7'h10,
        ST_WAIT    = 7'h20,
        ST_WRITE   = 7'h40
    } cyc_state_t;
    // One-hot port vector to port index.
    function automatic logic [PIDX_W-1:0] port_index(input logic [NPORT-1:0] onehot);
        logic [PIDX_W-1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < NPORT; i++) begin
            if (onehot[i]) begin
                idx = PIDX_W'(i);
            end
        end
        return idx;
    endfunction
endpackage

// ### rtl/port_arb_if.sv
// Request and grant bundle between the cycle control and its port arbiter.
`timescale 1ns/1ps
`default_nettype none
interface port_arb_if;
    import core_cyc_pkg::*;
    logic [NPORT-1:0] req;
    logic [NPORT-1:0] grant;
    logic             take;
    modport ctrl (output req, output take, input grant);
    modport arb  (input req, input take, output grant);
endinterface // port_arb_if
`default_nettype wire

// ### rtl/port_arbiter.sv
// Fixed priority A over B over C/D, with C and D taking turns.
`timescale 1ns/1ps
`default_nettype none
module port_arbiter
    import core_cyc_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    port_arb_if.arb   bus
);
    logic turn_d;
    wire  both_cd = bus.req[PORT_C] & bus.req[PORT_D];

    // Plain priority for A and B; C/D contention is settled by the turn bit.
    assign bus.grant[PORT_A] = bus.req[PORT_A];                                   // RULE_05
    assign bus.grant[PORT_B] = bus.req[PORT_B] & ~bus.req[PORT_A];                // RULE_05
    assign bus.grant[PORT_C] = bus.req[PORT_C] & ~|bus.req[PORT_B:PORT_A]
                               & ~(both_cd & turn_d);                            // RULE_05
    assign bus.grant[PORT_D] = bus.req[PORT_D] & ~|bus.req[PORT_B:PORT_A]
                               & ~(both_cd & ~turn_d);                           // RULE_05

    // The turn passes to the other of C and D whenever one of them is served.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            turn_d <= 1'b0;
        end else if (ce && bus.take && |bus.grant[PORT_D:PORT_C]) begin
            turn_d <= bus.grant[PORT_C];                                          // RULE_05
        end
    end

    default clocking cb @(posedge clk iff ce); endclocking
    default disable iff (!arst_n);

    property p_a_first;
        bus.req[PORT_A] |-> bus.grant == 4'h1;
    endproperty
    a_a_first: assert property (p_a_first) else $error("port A not preferred");   // RULE_05
    property p_cd_alt;
        both_cd && (bus.req[PORT_B:PORT_A] == 2'h0)
        |-> bus.grant[PORT_D:PORT_C] == {turn_d, ~turn_d};
    endproperty
    a_cd_alt: assert property (p_cd_alt) else $error("C and D did not alternate"); // RULE_05
    property p_turn_flip;
        bus.take && |bus.grant[PORT_D:PORT_C] |=> turn_d == $past(bus.grant[PORT_C]);
    endproperty
    a_turn_flip: assert property (p_turn_flip) else $error("turn not passed"); // RULE_05
endmodule // port_arbiter
`default_nettype wire

// ### bench/proc_port_model.sv
// Processor port model: raises one request, waits for acknowledge, then delivers write data on write kinds.
`timescale 1ns/1ps
`default_nettype none
module proc_port_model
    import core_cyc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              address_ack,
    input  wire logic              buffer_open,
    output var  logic              read_request,
    output var  logic              write_request,
    output var  logic              write_restart,
    output var  logic [ADDR_W-1:0] memory_address_lines,
    output var  logic [DATA_W-1:0] write_data
);
    // Request lines idle low; address and data lines start at zero.
    initial begin
        read_request = 1'b0;
        write_request = 1'b0;
        write_restart = 1'b0;
        memory_address_lines = 18'h00000;
        write_data = 36'h000000000;
    end

    // One transfer; a refused request is dropped after a fixed wait so the bench never hangs.
    task automatic run(input logic [1:0] kind, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input int dly, output logic ok);
        int n;
        ok = 1'b0;
        n = 0;
        @(posedge clk);
        #1;
        memory_address_lines = a;
        read_request = kind[1];
        write_request = kind[0];
        while (!ok && n < 100) begin
            @(negedge clk);
            ok = (address_ack === 1'b1);
            n++;
        end
        @(posedge clk);
        #1;
        read_request = 1'b0;
        write_request = 1'b0;
        // Released address shows the inverse so a late sample cannot pass by luck.
        memory_address_lines = ~a;
        if (ok && kind[0]) begin
            n = 0;
            while (buffer_open !== 1'b1 && n < 60) begin
                @(negedge clk);
                n++;
            end
            @(posedge clk);
            repeat (dly) @(posedge clk);
            #1;
            write_data = d;
            write_restart = 1'b1;
            repeat (6) @(posedge clk);
            #1;
            write_restart = 1'b0;
            write_data = ~d;
        end
    endtask
endmodule // proc_port_model
`default_nettype wire

// ### bench/test_core_memory_bus_cycle_control.sv
// Self-checking testbench for the core memory cycle control with four port models.
`timescale 1ns/1ps
`default_nettype none
module test_core_memory_bus_cycle_control;
    import core_cyc_pkg::*;
    localparam logic [SEL_W-1:0]  MOD_NUM = 4'h5;
    localparam logic [ADDR_W-1:0] ADR1    = {4'h5, 14'h0123};
    localparam logic [ADDR_W-1:0] ADR2    = {4'h5, 14'h0456};
    localparam logic [DATA_W-1:0] W1      = 36'h123456789;
    localparam logic [DATA_W-1:0] W2      = 36'hABCDE0123;
    localparam logic [DATA_W-1:0] W3      = 36'h5A5A5A5A5;
    logic                         clk;
    logic                         arst_n;
    logic                         special_mode_flag;
    wire logic [NPORT-1:0]        read_request;
    wire logic [NPORT-1:0]        write_request;
    wire logic [NPORT-1:0]        write_restart;
    wire logic [NPORT-1:0][ADDR_W-1:0] memory_address_lines;
    wire logic [NPORT-1:0][DATA_W-1:0] write_data;
    logic [NPORT-1:0]             address_ack;
    logic [NPORT-1:0]             read_restart;
    logic [NPORT-1:0]             data_strobe;
    logic [DATA_W-1:0]            read_data;
    logic [DATA_W-1:0]            last_data;
    logic                         buffer_open;
    logic                         busy;
    logic                         buf_at_ack;
    logic                         prev_ack;
    int                           mismatches;
    int                           n_checks;
    int                           strobe_port;
    int                           rr_port;
    int                           ack_q[$];

    core_memory_bus_cycle_control u_core_memory_bus_cycle_control (
        .clk(clk), .arst_n(arst_n), .ce(1'b1), .module_number(MOD_NUM),
        .special_mode_flag(special_mode_flag), .read_request(read_request),
        .write_request(write_request), .write_restart(write_restart),
        .memory_address_lines(memory_address_lines), .write_data(write_data),
        .address_ack(address_ack), .read_restart(read_restart), .data_strobe(data_strobe),
        .read_data(read_data), .buffer_open(buffer_open), .busy(busy));

    // One processor model per port.
    for (genvar i = 0; i < NPORT; i++) begin : g
        proc_port_model u_proc_port_model (
            .clk(clk), .address_ack(address_ack[i]), .buffer_open(buffer_open),
            .read_request(read_request[i]), .write_request(write_request[i]),
            .write_restart(write_restart[i]), .memory_address_lines(memory_address_lines[i]),
            .write_data(write_data[i]));
    end

    // Free-running bus clock.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Compare one value and count it.
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus monitor at mid-cycle, where registered and decoded outputs have settled.
    always @(negedge clk) begin
        if (address_ack !== 4'h0) begin
            chk(DATA_W'($countones(address_ack)), 36'h000000001);
            chk(DATA_W'(prev_ack), 36'h000000000);
            buf_at_ack = buffer_open;
            for (int i = 0; i < NPORT; i++) if (address_ack[i]) ack_q.push_back(i);
        end
        for (int i = 0; i < NPORT; i++) if (data_strobe[i] === 1'b1) strobe_port = i;
        for (int i = 0; i < NPORT; i++) if (read_restart[i] === 1'b1) rr_port = i;
        if (read_restart !== 4'h0) chk(DATA_W'(read_restart), DATA_W'(data_strobe));
        if (data_strobe !== 4'h0) last_data = read_data;
        prev_ack = (address_ack !== 4'h0);
    end

    // Run one transfer on a port chosen at run time.
    task automatic port_run(input int p, input logic [1:0] k, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] d, input int dly, output logic ok);
        case (p)
            0: g[0].u_proc_port_model.run(k, a, d, dly, ok);
            1: g[1].u_proc_port_model.run(k, a, d, dly, ok);
            2: g[2].u_proc_port_model.run(k, a, d, dly, ok);
            default: g[3].u_proc_port_model.run(k, a, d, dly, ok);
        endcase
    endtask

    // Wait for the cycle to end, bounded, and check that busy has dropped.
    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(DATA_W'(busy), 36'h000000000);
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Early write data on A, then a read-back on B.
    task automatic t_write_read;
        logic ok;
        port_run(PORT_A, KIND_WRITE, ADR1, W1, 0, ok);
        chk(DATA_W'(ok), 36'h000000001);
        chk(DATA_W'(buf_at_ack), 36'h000000001);
        wait_idle();
        strobe_port = 7;
        rr_port = 7;
        port_run(PORT_B, KIND_READ, ADR1, W1, 0, ok);
        wait_idle();
        chk(DATA_W'(strobe_port), 36'h000000001);
        chk(last_data, W1);
        chk(DATA_W'(rr_port), 36'h000000007);
        $display("test write_read done");
    endtask

    // Late restart on D forces a wait; A asks meanwhile and must see the new word.
    task automatic t_late_write;
        logic ok1;
        logic ok2;
        ack_q.delete();
        fork
            port_run(PORT_D, KIND_WRITE, ADR2, W2, 30, ok1);
            begin
                repeat (8) @(posedge clk);
                port_run(PORT_A, KIND_READ, ADR2, W2, 0, ok2);
            end
        join
        wait_idle();
        chk(DATA_W'(ack_q.size()), 36'h000000002);
        chk(DATA_W'(ack_q[0]), 36'h000000003);
        chk(last_data, W2);
        $display("test late_write done");
    endtask

    // Read-modify-write on C returns the old word, then stores the new one.
    task automatic t_rmw;
        logic ok;
        rr_port = 7;
        port_run(PORT_C, KIND_RMW, ADR1, W3, 2, ok);
        wait_idle();
        chk(last_data, W1);
        chk(DATA_W'(rr_port), 36'h000000002);
        port_run(PORT_B, KIND_READ, ADR1, W1, 0, ok);
        wait_idle();
        chk(last_data, W3);
        $display("test rmw done");
    endtask

    // All four ports at once, then C and D together again.
    task automatic t_priority;
        logic [NPORT-1:0] ok;
        int first_cd;
        ack_q.delete();
        fork
            port_run(PORT_A, KIND_READ, ADR2, W1, 0, ok[0]);
            port_run(PORT_B, KIND_READ, ADR2, W1, 0, ok[1]);
            port_run(PORT_C, KIND_READ, ADR2, W1, 0, ok[2]);
            port_run(PORT_D, KIND_READ, ADR2, W1, 0, ok[3]);
        join
        wait_idle();
        chk(DATA_W'(ack_q.size()), 36'h000000004);
        chk(DATA_W'(ack_q[0]), 36'h000000000);
        chk(DATA_W'(ack_q[1]), 36'h000000001);
        chk(DATA_W'(ack_q[2] + ack_q[3]), 36'h000000005);
        first_cd = ack_q[2];
        ack_q.delete();
        fork
            port_run(PORT_C, KIND_READ, ADR2, W1, 0, ok[2]);
            port_run(PORT_D, KIND_READ, ADR2, W1, 0, ok[3]);
        join
        wait_idle();
        chk(DATA_W'(ack_q[0]), DATA_W'(first_cd));
        chk(last_data, W2);
        $display("test priority done");
    endtask

    // Fast-memory addresses are refused, and foreign-module addresses unless special mode applies.
    task automatic t_refuse;
        logic ok;
        port_run(PORT_B, KIND_READ, {MOD_NUM, 14'h000F}, W1, 0, ok);
        chk(DATA_W'(ok), 36'h000000000);
        port_run(PORT_B, KIND_READ, {4'hA, 14'h0123}, W1, 0, ok);
        chk(DATA_W'(ok), 36'h000000000);
        special_mode_flag = 1'b1;
        port_run(PORT_B, KIND_READ, {4'hA, 14'h0123}, W1, 0, ok);
        chk(DATA_W'(ok), 36'h000000001);
        wait_idle();
        special_mode_flag = 1'b0;
        chk(last_data, W3);
        $display("test refuse done");
    endtask

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the roughly six hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        arst_n = 1'b0;
        special_mode_flag = 1'b0;
        mismatches = 0;
        n_checks = 0;
        prev_ack = 1'b0;
        buf_at_ack = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge clk);
        t_write_read();
        t_late_write();
        t_rmw();
        t_priority();
        t_refuse();
        end_of_test();
    end
endmodule // test_core_memory_bus_cycle_control
`default_nettype wire
